// ### rtl/rlt_pkg.sv
// Package for the reloadable 16-bit timer pair
package rlt_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] RLT_CTRL_OFS = 8'h00;
  localparam logic [7:0] RLT_COUNT_OFS = 8'h04;
  localparam logic [7:0] RLT_RELOAD_OFS = 8'h08;
  localparam logic [7:0] RLT_STATUS_OFS = 8'h0c;
  localparam logic [7:0] RLT_TIMER_STRIDE = 8'h10;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int RLT_CTRL_EN_BIT = 0;
  localparam int RLT_CTRL_MODE_LSB = 1;
  localparam int RLT_CTRL_PRES_LSB = 3;
  localparam int RLT_CTRL_POL_BIT = 6;
  localparam int RLT_CTRL_OUTEN_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [15:0] RLT_COUNT_RESTART = 16'h0001;
  localparam logic [15:0] RLT_COUNT_RST = 16'h0001;
  localparam logic [15:0] RLT_RELOAD_RST = 16'h0000;
  localparam logic [15:0] RLT_COUNT_MAX = 16'hffff;
  localparam logic [6:0] RLT_PRES_MAX_CNT = 7'h7f;
  localparam int RLT_NUM_TIMERS = 2;

  typedef enum logic [1:0]
  {
    RLT_MODE_ONE_SHOT,
    RLT_MODE_CONTINUOUS,
    RLT_MODE_COUNTER,
    RLT_MODE_RSVD
  } rlt_mode_t;

  typedef struct packed
  {
    logic out_en;
    logic output_polarity_select;
    logic [2:0] prescale;
    rlt_mode_t mode;
    logic enable;
  } rlt_ctrl_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rlt_bus_t;

endpackage : rlt_pkg

// ### rtl/rlt_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module rlt_sync
  import rlt_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level_o = level_reg;
endmodule : rlt_sync

// ### rtl/rlt_timer.sv
// One reloadable 16-bit timer channel
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module rlt_timer
  import rlt_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sel_i,
  input rlt_bus_t bus_i,
  input wire logic tin_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic tout_o
);
  rlt_ctrl_t ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [6:0] pres_reg;
  logic tin_lvl;
  logic tin_d_reg;
  logic out_lvl_reg;
  logic pulse_reg;
  logic irq_reg;
  logic tick;
  logic edge_seen;
  logic hit;
  logic [6:0] pres_lim;
  logic [7:0] loc;

  assign loc = bus_i.addr & (RLT_TIMER_STRIDE - 8'h01);
  assign pres_lim = 7'((8'h01 << ctrl_reg.prescale) - 8'h01);

  // ----------------------------------------------------------------
  // Timer input synchronise and edge detect
  // ----------------------------------------------------------------
  rlt_sync u_sync
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(tin_i),
    .level_o(tin_lvl)
  );

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tin_d_reg <= 1'b0;
    else
      tin_d_reg <= tin_lvl;
  end

  assign edge_seen = ctrl_reg.output_polarity_select ? (tin_lvl & ~tin_d_reg) : (~tin_lvl & tin_d_reg); // [R14] [R20]

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pres_reg <= 7'h00;
    else if (!ctrl_reg.enable || pres_reg >= pres_lim)
      pres_reg <= 7'h00;
    else
      pres_reg <= pres_reg + 7'h01; // [R3]
  end

  always_comb
  begin
    if (ctrl_reg.mode == RLT_MODE_COUNTER)
      tick = ctrl_reg.enable & edge_seen; // [R14]
    else
      tick = ctrl_reg.enable & (pres_reg >= pres_lim); // [R3] [R9]
  end

  assign hit = tick & (count_reg == reload_reg);

  // ----------------------------------------------------------------
  // Counter, reload and control
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_reg <= RLT_COUNT_RST;
      reload_reg <= RLT_RELOAD_RST;
      ctrl_reg <= '0;
    end
    else
    begin
      if (sel_i && bus_i.wr && loc == RLT_CTRL_OFS)
        ctrl_reg <= rlt_ctrl_t'(bus_i.wdata[7:0]); // [R21]
      else if (hit && ctrl_reg.mode == RLT_MODE_ONE_SHOT)
        ctrl_reg.enable <= 1'b0; // [R5]
      if (sel_i && bus_i.wr && loc == RLT_RELOAD_OFS)
        reload_reg <= bus_i.wdata[15:0];
      if (sel_i && bus_i.wr && loc == RLT_COUNT_OFS)
        count_reg <= bus_i.wdata[15:0]; // [R12]
      else if (hit)
        count_reg <= RLT_COUNT_RESTART; // [R5] [R10] [R12] [R17]
      else if (tick)
        count_reg <= count_reg + 16'h0001; // [R1] [R2] [R4] [R13] [R19]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and output pin
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_reg <= 1'b0;
      pulse_reg <= 1'b0;
      out_lvl_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= hit; // [R5] [R10] [R17]
      pulse_reg <= hit && ctrl_reg.mode == RLT_MODE_ONE_SHOT; // [R6]
      // Disabled write sets the level at once; running level holds
      if (sel_i && bus_i.wr && loc == RLT_CTRL_OFS && !bus_i.wdata[RLT_CTRL_EN_BIT])
        out_lvl_reg <= bus_i.wdata[RLT_CTRL_POL_BIT]; // [R15]
      else if (!ctrl_reg.enable)
        out_lvl_reg <= ctrl_reg.output_polarity_select; // [R15] [R21]
      else if (hit && ctrl_reg.mode != RLT_MODE_ONE_SHOT)
        out_lvl_reg <= ~out_lvl_reg; // [R11]
    end
  end

  assign irq_o = irq_reg;
  assign tout_o = ctrl_reg.out_en & (out_lvl_reg ^ pulse_reg); // [R6]

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    case (loc)
      RLT_CTRL_OFS: rdata_o = {24'h00_0000, ctrl_reg};
      RLT_COUNT_OFS: rdata_o = {16'h0000, count_reg};
      RLT_RELOAD_OFS: rdata_o = {16'h0000, reload_reg};
      RLT_STATUS_OFS: rdata_o = {30'h0000_0000, tin_lvl, tout_o};
      default: rdata_o = 32'h0000_0000;
    endcase
  end
endmodule : rlt_timer

// ### rtl/rlt_top.sv
// Top: two reloadable timers behind a simple register port
// What this block does
// [R1] Two independent 16-bit up-counters compared with 16-bit reload values.
// [R2] Count FFFFH wraps to 0000H and keeps counting.
// [R3] Clock modes advance once per prescale period, divisor 1 to 128.
// [R4] Reload 0001H/prescale 1 shortest; 0000H/prescale 128 longest.
// [R5] One-shot hit: interrupt, count to 0001H, enable cleared.
// [R6] One-shot hit inverts enabled output for one clock.
// [R7] Software presets polarity then flips it for lasting one-shot change.
// [R8] Software disables, configures, loads, then enables the timer.
// [R9] One-shot and continuous always count prescaled system clock.
// [R10] Continuous hit: interrupt, count to 0001H, keep counting.
// [R11] Continuous and counter hits toggle and hold output level.
// [R12] Written start count applies only to first pass.
// [R13] Period is reload times prescale; first pass reload minus start plus one.
// [R14] Counter mode counts polarity-selected input edges, prescaler bypassed.
// [R15] Counter polarity also sets the output initial level.
// [R16] Input toggles at most clock/4, phases at least two clocks.
// [R17] Counter hit: interrupt, count to 0001H, keep counting edges.
// [R18] Software loads 0001H before enabling counter mode.
// [R19] Counter minus start equals edges seen since enable.
// [R20] Input synchronised into clock domain before edge detection.
// [R21] Disabled timer holds values, stays writable, no events.
`timescale 1ns/1ps
module rlt_top
  import rlt_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [1:0] timer_in_i,
  output logic [1:0] timer_out_o,
  output logic [1:0] timer_irq_o
);
  rlt_bus_t bus;
  logic [31:0] rd_arr [RLT_NUM_TIMERS];
  logic [31:0] rdata_reg;
  logic hi_sel;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign hi_sel = (addr_i & RLT_TIMER_STRIDE) != 8'h00;

  // ----------------------------------------------------------------
  // Timer channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < RLT_NUM_TIMERS; g++)
  begin : g_tmr
    rlt_timer u_tmr
    (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .sel_i((addr_i < 8'h20) && (hi_sel == (g == 1))),
      .bus_i(bus),
      .tin_i(timer_in_i[g]),
      .rdata_o(rd_arr[g]),
      .irq_o(timer_irq_o[g]),
      .tout_o(timer_out_o[g])
    );
  end

  // ----------------------------------------------------------------
  // Registered read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_reg <= 32'h0000_0000;
    else if (rd_i && addr_i < 8'h20)
      rdata_reg <= hi_sel ? rd_arr[1] : rd_arr[0];
    else
      rdata_reg <= 32'h0000_0000;
  end

  assign rdata_o = rdata_reg;
endmodule : rlt_top

// ### tb/rlt_top_chk.sv
// Port checker for the timer pair
`timescale 1ns/1ps
module rlt_top_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] timer_in_i,
  input wire logic [1:0] timer_out_o,
  input wire logic [1:0] timer_irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  logic en_reg;
  // Last enable written to timer 0
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      en_reg <= 1'b0;
    else if (wr_i && addr_i == 8'h00)
      en_reg <= wdata_i[0];
  property p_hi;
    $past(rd_i) |-> rdata_o[31:16] == 16'h0000;
  endproperty
  a_hi: assert property (p_hi) else $error("read upper half set");
  property p_unmap;
    rd_i && addr_i[7:5] != 3'h0 |=> rdata_o == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rld;
    wr_i && addr_i == 8'h08 ##2 rd_i && addr_i == 8'h08 |=> rdata_o[15:0] == $past(wdata_i[15:0], 3);
  endproperty
  a_rld: assert property (p_rld) else $error("reload readback");
  property p_ctl;
    wr_i && addr_i == 8'h00 && !wdata_i[0] ##2 rd_i && addr_i == 8'h00 |=> rdata_o[7:0] == $past(wdata_i[7:0], 3);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control readback");
  property p_gate;
    wr_i && addr_i == 8'h00 && !wdata_i[7] |=> !timer_out_o[0];
  endproperty
  a_gate: assert property (p_gate) else $error("output not gated");
  property p_pol;
    wr_i && addr_i == 8'h00 && wdata_i[7] && !wdata_i[0] |=> timer_out_o[0] == $past(wdata_i[6]);
  endproperty
  a_pol: assert property (p_pol) else $error("output not at polarity");
  property p_off;
    !en_reg && !$past(en_reg) |-> !timer_irq_o[0];
  endproperty
  a_off: assert property (p_off) else $error("interrupt while disabled");
  property p_cause;
    $changed(timer_out_o[0]) |-> timer_irq_o[0] || $past(timer_irq_o[0]) || $past(wr_i);
  endproperty
  a_cause: assert property (p_cause) else $error("output moved without cause");
endmodule : rlt_top_chk

// ### tb/rlt_pin_mdl.sv
// Model of the pins feeding the timer inputs
`timescale 1ns/1ps
module rlt_pin_mdl (
  input wire logic clock_i,
  output logic [1:0] pin_o
);
  initial pin_o = 2'b00;
  // Phases of three clocks each
  task automatic pulses(input int g, input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clock_i);
      pin_o[g] <= 1'b1;
      repeat (3) @(posedge clock_i);
      pin_o[g] <= 1'b0;
    end
  endtask : pulses
endmodule : rlt_pin_mdl

// ### tb/testbench.sv
// Self-checking bench for the timer pair
`timescale 1ns/1ps
module testbench;
  import rlt_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  rlt_bus_t b = '0;
  logic [31:0] rdata_o, v;
  logic [1:0] tin, tout, irq;
  int n_fail = 0;
  int n_tests = 0;
  int t;
  always #10 clock_i = ~clock_i;
  rlt_pin_mdl pm_u (.clock_i(clock_i), .pin_o(tin));
  rlt_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(b.addr), .wdata_i(b.wdata), .wr_i(b.wr),
    .rd_i(b.rd), .rdata_o(rdata_o), .timer_in_i(tin), .timer_out_o(tout), .timer_irq_o(irq));
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    b <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_i);
    b <= '0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(logic [7:0] a);
    b <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clock_i);
    b <= '0;
    @(posedge clock_i);
    v = rdata_o;
  endtask : rd
  task automatic wirq(int g, int lim);
    t = 0;
    do
    begin
      @(posedge clock_i);
      t++;
    end
    while (irq[g] !== 1'b1 && t < lim);
  endtask : wirq
  function automatic logic [31:0] cw(logic oe, logic pl, logic [2:0] p, rlt_mode_t m, logic en);
    rlt_ctrl_t c;
    c = '{oe, pl, p, m, en};
    return {24'h00_0000, c};
  endfunction : cw
  task automatic stop_test();
    $display("checks %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic t_reg();
    rd(8'h20);
    chk("unmapped", v, 32'h0000_0000);
    wr(8'h04, 32'h0000_1234);
    wr(8'h08, 32'h0000_0005);
    rd(8'h08);
    chk("reload", v, 32'h0000_0005);
    wr(8'h00, cw(1'b0, 1'b0, 3'd0, RLT_MODE_RSVD, 1'b0));
    rd(8'h00);
    chk("ctrl", v, 32'h0000_0006);
    repeat (20) @(posedge clock_i);
    rd(8'h04);
    chk("hold", v, 32'h0000_1234);
    $display("t_reg done");
  endtask : t_reg
  task automatic t_cont();
    logic o;
    for (int p = 0; p < 4; p += 3)
    begin
      wr(8'h00, cw(1'b1, 1'b0, p[2:0], RLT_MODE_CONTINUOUS, 1'b0));
      wr(8'h04, 32'h0000_0001);
      wr(8'h08, 32'h0000_0003);
      wr(8'h00, cw(1'b1, 1'b0, p[2:0], RLT_MODE_CONTINUOUS, 1'b1));
      wirq(0, 100);
      o = tout[0];
      wirq(0, 100);
      chk("period", t, 3 << p);
      chk("toggle", 32'(tout[0]), 32'(!o));
    end
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_ffff);
    wr(8'h00, cw(1'b0, 1'b0, 3'd7, RLT_MODE_CONTINUOUS, 1'b1));
    repeat (190) @(posedge clock_i);
    rd(8'h04);
    chk("wrap", v, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    $display("t_cont done");
  endtask : t_cont
  task automatic t_one();
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, cw(1'b1, 1'b0, 3'd0, RLT_MODE_ONE_SHOT, 1'b0));
    wr(8'h00, cw(1'b1, 1'b0, 3'd0, RLT_MODE_ONE_SHOT, 1'b1));
    wirq(0, 100);
    chk("short", 32'(t < 4), 32'h0000_0001);
    chk("pulse", 32'(tout[0]), 32'h0000_0001);
    @(posedge clock_i);
    chk("back", 32'(tout[0]), 32'h0000_0000);
    wirq(0, 30);
    chk("once", t, 30);
    rd(8'h00);
    chk("off", v, 32'h0000_0080);
    rd(8'h04);
    chk("cnt", v, 32'h0000_0001);
    // Lasting level change: start at polarity 0, flip it while running
    wr(8'h08, 32'h0000_0004);
    wr(8'h00, cw(1'b1, 1'b0, 3'd2, RLT_MODE_ONE_SHOT, 1'b1));
    wr(8'h00, cw(1'b1, 1'b1, 3'd2, RLT_MODE_ONE_SHOT, 1'b1));
    chk("r7_hold", 32'(tout[0]), 32'h0000_0000);
    wirq(0, 100);
    chk("r7_pulse", 32'(tout[0]), 32'h0000_0001);
    repeat (2) @(posedge clock_i);
    chk("r7_last", 32'(tout[0]), 32'h0000_0001);
    rd(8'h0c);
    chk("status", v, 32'h0000_0001);
    $display("t_one done");
  endtask : t_one
  task automatic t_cnt();
    wr(8'h10, cw(1'b1, 1'b1, 3'd0, RLT_MODE_COUNTER, 1'b0));
    chk("init", 32'(tout[1]), 32'h0000_0001);
    wr(8'h14, 32'h0000_0001);
    wr(8'h18, 32'h0000_0005);
    wr(8'h10, cw(1'b1, 1'b1, 3'd0, RLT_MODE_COUNTER, 1'b1));
    pm_u.pulses(1, 3);
    repeat (8) @(posedge clock_i);
    rd(8'h14);
    chk("edges", v, 32'h0000_0004);
    pm_u.pulses(1, 2);
    wirq(1, 20);
    chk("hit", 32'(t < 20), 32'h0000_0001);
    rd(8'h14);
    chk("restart", v, 32'h0000_0001);
    chk("flip", 32'(tout[1]), 32'h0000_0000);
    $display("t_cnt done");
  endtask : t_cnt
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reg();
    t_cont();
    t_one();
    t_cnt();
    stop_test();
  end
  initial
  begin
    #100_000;
    n_fail++;
    stop_test();
  end
endmodule : testbench
bind rlt_top rlt_top_chk chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_in_i(timer_in_i), .timer_out_o(timer_out_o),
  .timer_irq_o(timer_irq_o));
